// ---- common/cfe_pkg.sv ----
// constants for the cascaded fifo expansion unit
package cfe_pkg;
    localparam int DEPTH = 128;
    localparam int AW = 7;
    localparam int DW = 8;
    localparam logic [7:0] FULL_COUNT = 8'h80;
    // register indices
    localparam logic [3:0] IDX_CTRL0 = 4'h0;
    localparam logic [3:0] IDX_CTRL3 = 4'h1;
    localparam logic [3:0] IDX_STATUS = 4'h2;
    localparam logic [3:0] IDX_COUNT = 4'h3;
    localparam logic [3:0] IDX_CMP = 4'h4;
    localparam logic [3:0] IDX_MSG = 4'h5;
    localparam logic [3:0] IDX_DATA = 4'h6;
    // control register zero fields
    localparam int C0_JUSTIFY = 1;
    localparam int C0_CASCADE = 2;
    localparam int C0_DIR_MASTER = 3;
    localparam int C0_DIR = 4;
    localparam int C0_DMA_EN = 5;
    localparam int C0_EMPTY_IE = 6;
    localparam int C0_FULL_IE = 7;
    localparam int C0_CLEAR = 8;
    localparam int C0_W = 9;
    localparam logic [8:0] C0_RESET = 9'h000;
    // control register three fields
    localparam int C3_MIRROR = 0;
    localparam int C3_FLAG = 1;
    localparam int C3_INBOUND = 2;
    // status fields
    localparam int ST_FULL = 0;
    localparam int ST_EMPTY = 1;
    localparam int ST_ALL_FULL = 2;
    localparam int ST_ALL_EMPTY = 3;
    localparam int ST_DIR = 4;
    localparam logic [7:0] CMP_RESET = 8'h00;
endpackage

// ---- rtl/cfe_unit.sv ----
// one 128-byte fifo unit with apb side and interlocked handshake cascade side
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module cfe_unit (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] link_data_i,
    output logic [7:0] link_data_o,
    output logic link_data_oe_o,
    input wire logic acknowledge_input_n_i,
    output logic link_strobe_o,
    input wire logic direction_i,
    output logic direction_o,
    output logic direction_oe_o,
    input wire logic inbound_flag_pin_i,
    output logic outbound_flag_pin_o,
    input wire logic full_line_i,
    output logic full_oe_o,
    input wire logic empty_line_i,
    output logic empty_oe_o,
    output logic irq_o,
    output logic dma_req_o,
    output logic buffer_clear_n_o
);
    logic [cfe_pkg::DW-1:0] mem [cfe_pkg::DEPTH];
    logic [cfe_pkg::AW-1:0] wptr_reg;
    logic [cfe_pkg::AW-1:0] rptr_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic full_reg;
    logic empty_reg;
    logic [cfe_pkg::C0_W-1:0] ctrl0_reg;
    logic flag_reg;
    logic [7:0] cmp_reg;
    logic [7:0] msg_reg;
    logic [7:0] rdata_next;
    logic in_valid_reg;
    logic [7:0] in_data_reg;
    logic out_valid_reg;
    logic [7:0] out_data_reg;
    logic [12:0] sync1_reg;
    logic [12:0] sync2_reg;
    logic ack_prev_reg;
    logic pready_reg;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 13'h1FFF;
            sync2_reg <= 13'h1FFF;
            ack_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {acknowledge_input_n_i, direction_i, inbound_flag_pin_i,
                          full_line_i, empty_line_i, link_data_i};
            sync2_reg <= sync1_reg;
            ack_prev_reg <= sync2_reg[12];
        end
    end

    logic ack_high;
    logic ack_fall;
    logic dir_pin;
    logic inbound_s;
    logic all_full;
    logic all_empty;
    logic [7:0] link_s;
    assign ack_high = sync2_reg[12];
    assign ack_fall = ack_prev_reg & ~sync2_reg[12];
    assign dir_pin = sync2_reg[11];
    assign inbound_s = sync2_reg[10];
    assign all_full = sync2_reg[9];
    assign all_empty = sync2_reg[8];
    assign link_s = sync2_reg[7:0];

    // ------------------------------------------------------------
    // direction and apb decode
    // ------------------------------------------------------------
    logic dir;
    logic clr;
    logic justify;
    logic [3:0] idx;
    logic mapped;
    logic acc;
    logic done;
    logic data_acc;
    logic stall;
    // the inverter between units sits outside; a slave unit just takes the pin
    assign dir = ctrl0_reg[cfe_pkg::C0_DIR_MASTER] ? ctrl0_reg[cfe_pkg::C0_DIR] : dir_pin;
    assign clr = ctrl0_reg[cfe_pkg::C0_CLEAR];
    assign justify = ctrl0_reg[cfe_pkg::C0_JUSTIFY];
    assign idx = justify ? paddr_i[5:2] : paddr_i[6:3];
    assign mapped = (justify | paddr_i[2]) & (idx <= cfe_pkg::IDX_DATA);
    assign acc = psel_i & penable_i;
    assign done = acc & pready_reg;
    assign data_acc = mapped & (idx == cfe_pkg::IDX_DATA);
    // wait state: hold a data write off while this unit is full in output mode
    assign stall = data_acc & pwrite_i & ~dir & full_reg;

    // ------------------------------------------------------------
    // push and pop sources
    // ------------------------------------------------------------
    logic push;
    logic pop;
    logic pop_link;
    logic [7:0] push_data;
    // link side pushes in input mode, cpu pushes in output mode
    assign push = ~clr & ~full_reg & (dir ? in_valid_reg
                  : (done & pwrite_i & data_acc));
    assign push_data = dir ? in_data_reg : pwdata_i[7:0];
    // next byte strobed out once the partner's acknowledge is back high
    assign pop_link = ~clr & ~dir & ~out_valid_reg & ack_high & ~empty_reg;
    assign pop = pop_link | (~clr & dir & ~empty_reg & done & ~pwrite_i & data_acc);

    always_comb begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + 8'h01;
        end else if (pop & ~push) begin
            count_next = count_reg - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr_reg] <= push_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= 8'h00;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 7'h01;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 7'h01;
            end
            count_reg <= count_next;
            full_reg <= (count_next == cfe_pkg::FULL_COUNT);
            empty_reg <= (count_next == 8'h00);
        end
    end

    // ------------------------------------------------------------
    // link handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr) begin
            in_valid_reg <= 1'b0;
            in_data_reg <= 8'h00;
        end else if (dir && !in_valid_reg && ack_fall) begin
            in_valid_reg <= 1'b1;
            in_data_reg <= link_s;
        end else if (push && dir) begin
            in_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= 8'h00;
        end else if (pop_link) begin
            out_valid_reg <= 1'b1;
            out_data_reg <= mem[rptr_reg];
        end else if (!dir && out_valid_reg && ack_fall) begin
            out_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link_strobe_o <= 1'b1;
            link_data_o <= 8'h00;
            link_data_oe_o <= 1'b0;
        end else begin
            // ready for byte in input mode, byte available (low active) in output mode
            link_strobe_o <= dir ? (~in_valid_reg & ~full_reg & ack_high & ~clr)
                             : ~out_valid_reg;
            link_data_o <= out_data_reg;
            link_data_oe_o <= ~dir;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic wr;
    assign wr = done & pwrite_i & mapped;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl0_reg <= cfe_pkg::C0_RESET;
        end else if (wr && idx == cfe_pkg::IDX_CTRL0) begin
            ctrl0_reg <= pwdata_i[cfe_pkg::C0_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_reg <= 1'b0;
        end else if (wr && idx == cfe_pkg::IDX_CTRL3) begin
            flag_reg <= pwdata_i[cfe_pkg::C3_FLAG];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_reg <= cfe_pkg::CMP_RESET;
        end else if (wr && idx == cfe_pkg::IDX_CMP) begin
            cmp_reg <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            msg_reg <= 8'h00;
        end else if (wr && idx == cfe_pkg::IDX_MSG && !ctrl0_reg[cfe_pkg::C0_CASCADE]) begin
            msg_reg <= pwdata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        case (idx)
            cfe_pkg::IDX_CTRL0: rdata_next = ctrl0_reg[7:0];
            cfe_pkg::IDX_CTRL3: begin
                rdata_next[cfe_pkg::C3_MIRROR] = flag_reg;
                rdata_next[cfe_pkg::C3_FLAG] = flag_reg;
                rdata_next[cfe_pkg::C3_INBOUND] = inbound_s;
            end
            cfe_pkg::IDX_STATUS: begin
                rdata_next[cfe_pkg::ST_FULL] = full_reg;
                rdata_next[cfe_pkg::ST_EMPTY] = empty_reg;
                rdata_next[cfe_pkg::ST_ALL_FULL] = all_full;
                rdata_next[cfe_pkg::ST_ALL_EMPTY] = all_empty;
                rdata_next[cfe_pkg::ST_DIR] = dir;
            end
            cfe_pkg::IDX_COUNT: rdata_next = count_reg;
            cfe_pkg::IDX_CMP: rdata_next = cmp_reg;
            cfe_pkg::IDX_MSG: rdata_next = ctrl0_reg[cfe_pkg::C0_CASCADE] ? 8'h00 : msg_reg;
            cfe_pkg::IDX_DATA: rdata_next = (dir && !empty_reg) ? mem[rptr_reg] : 8'h00;
            default: rdata_next = 8'h00;
        endcase
        if (!mapped) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_reg <= 1'b0;
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_reg <= acc & ~pready_reg & ~stall;
            if (acc && !pready_reg && !stall) begin
                prdata_o <= {24'h000000, rdata_next};
                pslverr_o <= ~mapped;
            end
        end
    end
    assign pready_o = pready_reg;

    // ------------------------------------------------------------
    // side outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            full_oe_o <= 1'b1;
            empty_oe_o <= 1'b0;
            irq_o <= 1'b0;
            dma_req_o <= 1'b0;
            outbound_flag_pin_o <= 1'b0;
            direction_o <= 1'b0;
            direction_oe_o <= 1'b0;
            buffer_clear_n_o <= 1'b1;
        end else begin
            // open drain: pull low while not full / not empty
            full_oe_o <= ~full_reg;
            empty_oe_o <= ~empty_reg;
            irq_o <= (ctrl0_reg[cfe_pkg::C0_EMPTY_IE] & all_empty)
                     | (ctrl0_reg[cfe_pkg::C0_FULL_IE] & all_full);
            dma_req_o <= ctrl0_reg[cfe_pkg::C0_DMA_EN] & (count_reg <= cmp_reg);
            outbound_flag_pin_o <= flag_reg;
            direction_o <= ctrl0_reg[cfe_pkg::C0_DIR];
            direction_oe_o <= ctrl0_reg[cfe_pkg::C0_DIR_MASTER];
            buffer_clear_n_o <= ~clr;
        end
    end
endmodule

// ---- tb/cfe_unit_properties.sv ----
// assertion checker for the cascade fifo unit
`timescale 1ns/1ns
module cfe_unit_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic [7:0] link_data_o,
    input wire logic link_data_oe_o,
    input wire logic acknowledge_input_n_i,
    input wire logic link_strobe_o,
    input wire logic direction_oe_o,
    input wire logic outbound_flag_pin_o,
    input wire logic full_line_i,
    input wire logic full_oe_o,
    input wire logic empty_line_i,
    input wire logic empty_oe_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire wr = psel_i && penable_i && pwrite_i && pready_o;
    sequence s_full_in;
        (!full_oe_o && !link_data_oe_o) [*3];
    endsequence
    sequence s_ack_low;
        (!acknowledge_input_n_i && !link_data_oe_o) [*8];
    endsequence
    sequence s_lines_idle;
        (!full_line_i && !empty_line_i) [*5];
    endsequence
    property p_full_ready;
        s_full_in |-> !$past(link_strobe_o);
    endproperty
    property p_ack_low;
        s_ack_low |-> !link_strobe_o;
    endproperty
    property p_out_stable;
        link_data_oe_o && !link_strobe_o && !$past(link_strobe_o) |-> $stable(link_data_o);
    endproperty
    property p_irq_lines;
        s_lines_idle |-> !irq_o;
    endproperty
    property p_flag_src;
        $changed(outbound_flag_pin_o) |-> $past(wr) || $past(wr, 2);
    endproperty
    property p_dir_src;
        $changed(direction_oe_o) |-> $past(wr) || $past(wr, 2);
    endproperty
    property p_oe_excl;
        full_oe_o || empty_oe_o;
    endproperty
    property p_pready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_full_ready: assert property (p_full_ready) else $error("ready while full");
    a_ack_low: assert property (p_ack_low) else $error("ready with ack low");
    a_out_stable: assert property (p_out_stable) else $error("out byte moved");
    a_irq_lines: assert property (p_irq_lines) else $error("irq without line");
    a_flag_src: assert property (p_flag_src) else $error("flag moved alone");
    a_dir_src: assert property (p_dir_src) else $error("direction moved");
    a_oe_excl: assert property (p_oe_excl) else $error("full and empty");
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");
endmodule
bind cfe_unit cfe_unit_checker u_cfe_unit_checker (.clk_i, .rst_n_i, .psel_i, .penable_i,
    .pwrite_i, .pready_o, .link_data_o, .link_data_oe_o, .acknowledge_input_n_i,
    .link_strobe_o, .direction_oe_o, .outbound_flag_pin_o, .full_line_i, .full_oe_o,
    .empty_line_i, .empty_oe_o, .irq_o);

// ---- tb/cfe_far.sv ----
// far-end handshake model: byte source or byte sink
`timescale 1ns/1ns
module cfe_far (
    input wire logic clk_i,
    input wire logic strobe_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic ack_n_o
);
    logic [7:0] rx_q[$];
    bit sink_en = 0;
    int lag = 0;
    initial begin
        ack_n_o = 1'b1;
        data_o = 8'hA5;
    end
    task automatic send(input logic [7:0] b, output bit ok);
        int k;
        k = 0;
        while (strobe_i !== 1'b1 && k < 90) begin
            @(posedge clk_i);
            k++;
        end
        data_o <= b;
        ack_n_o <= 1'b0;
        while (strobe_i !== 1'b0 && k < 90) begin
            @(posedge clk_i);
            k++;
        end
        repeat (lag) @(posedge clk_i);
        ack_n_o <= 1'b1;
        data_o <= ~b;
        ok = k < 90;
    endtask
    // take one byte per low strobe, optionally slow
    always begin
        @(posedge clk_i);
        if (sink_en && strobe_i === 1'b0) begin
            repeat (lag) @(posedge clk_i);
            rx_q.push_back(data_i);
            ack_n_o <= 1'b0;
            repeat (60) if (strobe_i !== 1'b1) @(posedge clk_i);
            ack_n_o <= 1'b1;
        end
    end
endmodule

// ---- tb/cascaded_fifo_expansion_bench.sv ----
// self-checking bench for the cascade fifo unit
`timescale 1ns/1ns
module cascaded_fifo_expansion_bench;
    logic clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, q, fl, seed = 32'h58;
    logic pready_o, pslverr_o, err, oe, strobe, ack_n, dir_o, dir_oe, inb = 0;
    logic out_flag, full_oe, empty_oe, irq_o, dma_req_o, clr_n;
    logic [7:0] din, dout, exp_q[$];
    int miscompares = 0, cmp_count = 0, i;
    always #25 clk_i = ~clk_i;
    cfe_unit u_cfe_unit (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link_data_i(din), .link_data_o(dout),
        .link_data_oe_o(oe), .acknowledge_input_n_i(ack_n), .link_strobe_o(strobe),
        .direction_i(dir_oe ? !dir_o : 1'b1), .direction_o(dir_o), .direction_oe_o(dir_oe),
        .inbound_flag_pin_i(inb), .outbound_flag_pin_o(out_flag), .full_line_i(!full_oe),
        .full_oe_o(full_oe), .empty_line_i(!empty_oe), .empty_oe_o(empty_oe), .irq_o,
        .dma_req_o, .buffer_clear_n_o(clr_n));
    cfe_far u_cfe_far (.clk_i, .strobe_i(strobe), .data_i(dout), .data_o(din), .ack_n_o(ack_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] adr(input logic [3:0] idx);
        return {25'h0, idx, 3'h4};
    endfunction
    function automatic logic [31:0] exp_dma(input int c, input int m);
        return 32'(c <= m);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic push_in(input int n);
        bit ok;
        logic [7:0] b;
        repeat (n) begin
            b = 8'(rnd());
            u_cfe_far.send(b, ok);
            exp_q.push_back(b);
            chk("sent", 32'h1, 32'(ok));
        end
    endtask
    task automatic pop(input int n);
        repeat (n) begin
            apb(1'b0, adr(4'h6), 32'h0);
            chk("data", {24'h0, exp_q.pop_front()}, q);
        end
    endtask
    task automatic rd(input string nm, input logic [3:0] idx, input logic [31:0] e);
        apb(1'b0, adr(idx), 32'h0);
        chk(nm, e, q);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(40000 * 50);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk("strobe", 32'h1, 32'(strobe));
        apb(1'b0, 32'h0, 32'h0);
        chk("even word", 32'h1, 32'(err));
        apb(1'b0, adr(4'h7), 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        rd("status", 4'h2, 32'h1A);
        apb(1'b1, adr(4'h0), 32'h2);
        apb(1'b0, 32'h8, 32'h0);
        chk("justified", 32'h1A, q);
        apb(1'b1, 32'h0, 32'h0);
        fl = rnd();
        inb <= fl[1];
        apb(1'b1, adr(4'h1), {30'h0, fl[0], 1'b0});
        repeat (4) @(posedge clk_i);
        rd("ctrl3", 4'h1, {29'h0, fl[1], fl[0], fl[0]});
        chk("flag pin", 32'(fl[0]), 32'(out_flag));
        $display("test registers done");
        apb(1'b1, adr(4'h0), 32'h3C);
        apb(1'b1, adr(4'h5), 32'h5A);
        rd("msg", 4'h5, 32'h0);
        apb(1'b1, adr(4'h4), 32'h0A);
        chk("dir pin", 32'h1, 32'(dir_o));
        u_cfe_far.lag = 10;
        push_in(12);
        u_cfe_far.lag = 0;
        repeat (6) @(posedge clk_i);
        rd("count", 4'h3, 32'd12);
        chk("dma", exp_dma(12, 10), 32'(dma_req_o));
        pop(2);
        repeat (3) @(posedge clk_i);
        chk("dma", exp_dma(10, 10), 32'(dma_req_o));
        pop(10);
        repeat (4) @(posedge clk_i);
        rd("status", 4'h2, 32'h1A);
        apb(1'b1, adr(4'h0), 32'h7C);
        repeat (5) @(posedge clk_i);
        chk("irq empty", 32'h1, 32'(irq_o));
        $display("test input done");
        push_in(128);
        repeat (10) @(posedge clk_i);
        rd("status", 4'h2, 32'h15);
        chk("ready low", 32'h0, 32'(strobe));
        chk("irq full", 32'h0, 32'(irq_o));
        fork
            pop(40);
            push_in(20);
        join
        pop(108);
        $display("test full done");
        apb(1'b1, adr(4'h0), 32'h2C);
        repeat (2) @(posedge clk_i);
        chk("dir pin", 32'h0, 32'(dir_o));
        chk("dir oe", 32'h1, 32'(dir_oe));
        chk("data oe", 32'h1, 32'(oe));
        u_cfe_far.lag = 3;
        u_cfe_far.sink_en = 1;
        for (i = 0; i < 20; i++) begin
            fl = rnd();
            exp_q.push_back(fl[7:0]);
            apb(1'b1, adr(4'h6), {24'h0, fl[7:0]});
        end
        for (i = 0; i < 400 && u_cfe_far.rx_q.size() < 20; i++) @(posedge clk_i);
        chk("out count", 32'd20, 32'(u_cfe_far.rx_q.size()));
        while (u_cfe_far.rx_q.size() > 0)
            chk("out byte", {24'h0, exp_q.pop_front()}, {24'h0, u_cfe_far.rx_q.pop_front()});
        $display("test output done");
        u_cfe_far.sink_en = 0;
        repeat (8) @(posedge clk_i);
        apb(1'b1, adr(4'h0), 32'hAC);
        // one byte sits in the link holding stage, 128 fill the store
        for (i = 0; i < 129; i++)
            apb(1'b1, adr(4'h6), 32'(i));
        repeat (6) @(posedge clk_i);
        rd("status", 4'h2, 32'h05);
        chk("irq full", 32'h1, 32'(irq_o));
        fork
            apb(1'b1, adr(4'h6), 32'h77);
            begin
                repeat (20) @(posedge clk_i);
                chk("wait", 32'h0, 32'(pready_o));
                u_cfe_far.sink_en = 1;
            end
        join
        apb(1'b1, adr(4'h0), 32'h12C);
        rd("cleared", 4'h3, 32'h0);
        chk("ctrl reset", 32'h0, 32'(rst_n_i & clr_n));
        apb(1'b1, adr(4'h0), 32'h2C);
        repeat (2) @(posedge clk_i);
        chk("ctrl reset", 32'h1, 32'(rst_n_i & clr_n));
        $display("test wait and clear done");
        report_and_stop();
    end
endmodule
